/* hdl/sequencer_pkg.sv */
// Purpose: Shared constants for the programmable S/R state sequencer
// Assumes: One system clock; the device clock pin is a sampled input
// Notes: Variable vector order is ext, diag select, state bits, C
package sequencer_pkg;
  localparam int ext_inputs = 11;
  localparam int state_width = 10;
  localparam int out_width = 4;
  localparam int ff_count = 14;
  localparam int num_vars = 23;
  localparam int default_terms = 48;
  localparam int diag_pos = 11;
  localparam int state_pos = 12;
  localparam int c_pos = 22;
  localparam int out_pos = 10;
  localparam logic [13:0] regs_reset = 14'h3fff;
endpackage

/* hdl/term_array.sv */
// Purpose: Programmable AND plane producing the transition terms
// Assumes: Links given as true and complement masks per term
// Notes: Both links intact on any variable inhibits the term, except on C while use_c is low
`timescale 1ns/1ns
module term_array #(
  parameter int num_terms = 48,
  parameter int num_vars = 23,
  parameter logic [num_terms*num_vars-1:0] true_links = '1,
  parameter logic [num_terms*num_vars-1:0] comp_links = '1
) (
  input wire logic [num_vars-1:0] vars,
  input wire logic use_c,
  output logic [num_terms-1:0] terms
);
  logic [num_vars-1:0] c_keep;

  if (num_vars <= sequencer_pkg::c_pos) begin : g_bad_vars
    $error("num_vars must exceed the C variable position");
  end

  // First pass must not look at C, otherwise C loops on itself
  assign c_keep = use_c ? {num_vars{1'b1}} :
                  ~({{(num_vars-1){1'b0}}, 1'b1} << sequencer_pkg::c_pos);

  genvar t;
  generate
    for (t = 0; t < num_terms; t++) begin : g_term
      logic [num_vars-1:0] mt;
      logic [num_vars-1:0] mc;
      assign mt = true_links[t*num_vars +: num_vars] & c_keep;
      assign mc = comp_links[t*num_vars +: num_vars] & c_keep;
      assign terms[t] = &((vars | ~mt) & (~vars | ~mc));
    end
  endgenerate
endmodule

/* hdl/sr_sequencer.sv */
// Purpose: Field-programmable Mealy sequencer with S/R flip-flop registers
// Assumes: Device clock pin and preset pin are synchronous to clock
// Notes: Both set and reset active holds the bit; the value is kept unchanged
// Summary of operation
// - Apart from reset and preset, registers change only on a rising edge of the device clock pin.
// - Term array uses eleven external inputs plus the diag select input.
// - Diagnostic mode shows state bits 6-9 and 4-5 on the pins.
// - Diagnostic mode changes only the pins, never register contents.
// - Diagnostic mode drives output pins 0 and 1 high.
// - Normal mode shows state bits 0-3 and output register bits 0-3.
// - Preset high forces all bits to one and blocks clocking.
// - After preset release, wait for a falling clock edge before updating.
// - Enable option: low enables outputs, high floats them, registers kept.
// - Shared pin acts as preset or as enable, chosen by an option.
// - Reset presets every state and output bit to one.
// - Unprogrammed: terms and set/reset inputs disabled, pin acts as preset.
// - Terms over inputs and fed-back state are ORed into set and reset.
// - Neither set nor reset active at an edge keeps the bit.
// - Complement array NOR of chosen terms feeds back into the terms.
`timescale 1ns/1ns
module sr_sequencer #(
  parameter int num_terms = sequencer_pkg::default_terms,
  parameter logic [num_terms*sequencer_pkg::num_vars-1:0] and_true_links = '1,
  parameter logic [num_terms*sequencer_pkg::num_vars-1:0] and_comp_links = '1,
  parameter logic [num_terms*sequencer_pkg::ff_count-1:0] set_links = '0,
  parameter logic [num_terms*sequencer_pkg::ff_count-1:0] reset_links = '0,
  parameter logic [num_terms-1:0] complement_links = '0,
  parameter logic preset_option = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic device_clock_pin,
  input wire logic [sequencer_pkg::ext_inputs-1:0] logic_inputs,
  input wire logic diag_select_input,
  input wire logic diag_voltage_high,
  input wire logic preset_or_enable_pin,
  output logic [3:0] state_output_pins,
  output logic state_output_oe,
  output logic [3:0] output_pins,
  output logic output_pins_oe
);
  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (num_terms < 1 || num_terms > 64) begin : g_bad_terms
    $error("num_terms must lie in 1 to 64");
  end

  // ----------------------------------------------------------------
  // Term arrays and complement variable
  // ----------------------------------------------------------------
  logic [13:0] regs_ff;
  logic [13:0] nxt_regs;
  logic clk_pin_ff;
  logic nxt_clk_pin;
  logic wait_fall_ff;
  logic nxt_wait_fall;
  logic [sequencer_pkg::num_vars-1:0] vars_first;
  logic [sequencer_pkg::num_vars-1:0] vars_second;
  logic [num_terms-1:0] terms_first;
  logic [num_terms-1:0] terms;
  logic c_var;
  logic [13:0] set_cmd;
  logic [13:0] rst_cmd;
  logic preset_active;
  logic rising_edge;
  logic falling_edge;
  logic take_edge;
  logic diag_mode;

  assign vars_first = {1'b0, regs_ff[sequencer_pkg::state_width-1:0],
                       diag_select_input, logic_inputs};
  assign vars_second = {c_var, vars_first[sequencer_pkg::c_pos-1:0]};

  term_array #(
    .num_terms(num_terms),
    .num_vars(sequencer_pkg::num_vars),
    .true_links(and_true_links),
    .comp_links(and_comp_links)
  ) u_first (
    .vars(vars_first),
    .use_c(1'b0),
    .terms(terms_first)
  );

  assign c_var = ~|(terms_first & complement_links);

  term_array #(
    .num_terms(num_terms),
    .num_vars(sequencer_pkg::num_vars),
    .true_links(and_true_links),
    .comp_links(and_comp_links)
  ) u_second (
    .vars(vars_second),
    .use_c(1'b1),
    .terms(terms)
  );

  genvar f;
  generate
    for (f = 0; f < sequencer_pkg::ff_count; f++) begin : g_or
      assign set_cmd[f] = |(terms & set_links[f*num_terms +: num_terms]);
      assign rst_cmd[f] = |(terms & reset_links[f*num_terms +: num_terms]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Clock pin edges and preset control
  // ----------------------------------------------------------------
  // Single function
  assign preset_active = preset_option & preset_or_enable_pin;
  assign rising_edge = device_clock_pin & ~clk_pin_ff;
  assign falling_edge = ~device_clock_pin & clk_pin_ff;
  assign take_edge = rising_edge & ~wait_fall_ff & ~preset_active;
  assign diag_mode = diag_voltage_high;

  always_comb begin
    nxt_clk_pin = device_clock_pin;
    nxt_wait_fall = wait_fall_ff;
    nxt_regs = regs_ff;
    if (preset_active) begin
      nxt_wait_fall = 1'b1;
    end else if (falling_edge) begin
      nxt_wait_fall = 1'b0;
    end
    if (preset_active) begin
      nxt_regs = sequencer_pkg::regs_reset;
    end else if (take_edge) begin
      // Set or reset, hold otherwise; diag ignored
      nxt_regs = (regs_ff & ~(rst_cmd & ~set_cmd)) | (set_cmd & ~rst_cmd);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      regs_ff <= sequencer_pkg::regs_reset;
      wait_fall_ff <= 1'b1;
      clk_pin_ff <= 1'b0;
    end else begin
      regs_ff <= nxt_regs;
      wait_fall_ff <= nxt_wait_fall;
      clk_pin_ff <= nxt_clk_pin;
    end
  end

  // ----------------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------------
  // Preset reaches the pins at once, not a cycle later
  always_comb begin
    if (preset_active) begin
      state_output_pins = 4'hf;
      output_pins = 4'hf;
    end else if (diag_mode) begin
      // Hidden state bits, low pins high
      state_output_pins = regs_ff[9:6];
      output_pins = {regs_ff[5:4], 2'b11};
    end else begin
      state_output_pins = regs_ff[3:0];
      output_pins = regs_ff[13:10];
    end
  end

  assign state_output_oe = preset_option | ~preset_or_enable_pin;
  assign output_pins_oe = preset_option | ~preset_or_enable_pin;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_release;
    preset_active ##1 !preset_active;
  endsequence

  sequence s_rise_no_fall;
    !falling_edge && !preset_active && !rising_edge ##1
      rising_edge && !preset_active;
  endsequence

  property p_no_edge_hold;
    @(posedge clock) disable iff (rst)
      !rising_edge && !preset_active |=> $stable(regs_ff);
  endproperty
  a_no_edge_hold: assert property (p_no_edge_hold)
    else $error("registers changed without a clock pin rise");

  property p_diag_view;
    @(posedge clock) disable iff (rst)
      diag_mode && !preset_active |-> state_output_pins == regs_ff[9:6]
        && output_pins[3:2] == regs_ff[5:4];
  endproperty
  a_diag_view: assert property (p_diag_view)
    else $error("diagnostic pins do not show state bits");

  property p_diag_keep;
    @(posedge clock) disable iff (rst)
      diag_mode && !take_edge && !preset_active |=> $stable(regs_ff);
  endproperty
  a_diag_keep: assert property (p_diag_keep)
    else $error("diagnostic mode altered register contents");

  property p_diag_ones;
    @(posedge clock) disable iff (rst)
      diag_mode |-> output_pins[1:0] == 2'b11;
  endproperty
  a_diag_ones: assert property (p_diag_ones)
    else $error("output pins 0 and 1 not high in diagnostic mode");

  property p_normal_view;
    @(posedge clock) disable iff (rst)
      !diag_mode && !preset_active |-> state_output_pins == regs_ff[3:0]
        && output_pins == regs_ff[13:10];
  endproperty
  a_normal_view: assert property (p_normal_view)
    else $error("normal mode pins wrong");

  property p_preset_ones;
    @(posedge clock) disable iff (rst)
      preset_active [*2] |-> regs_ff == sequencer_pkg::regs_reset
        && output_pins == 4'hf;
  endproperty
  a_preset_ones: assert property (p_preset_ones)
    else $error("preset did not hold all bits at one");

  property p_wait_after_release;
    @(posedge clock) disable iff (rst)
      s_release ##0 s_rise_no_fall |=> $stable(regs_ff);
  endproperty
  a_wait_after_release: assert property (p_wait_after_release)
    else $error("clock taken before a falling edge after preset");

  property p_enable_pin;
    @(posedge clock) disable iff (rst)
      !preset_option |-> output_pins_oe == !preset_or_enable_pin
        && state_output_oe == !preset_or_enable_pin;
  endproperty
  a_enable_pin: assert property (p_enable_pin)
    else $error("output enable does not follow active-low pin");

  property p_reset_ones;
    @(posedge clock) rst |=> regs_ff == sequencer_pkg::regs_reset;
  endproperty
  a_reset_ones: assert property (p_reset_ones)
    else $error("reset did not preset all bits");

  property p_hold_inactive;
    @(posedge clock) disable iff (rst)
      take_edge |=> ((regs_ff ^ $past(regs_ff))
        & ~$past(set_cmd | rst_cmd)) == 14'h0000;
  endproperty
  a_hold_inactive: assert property (p_hold_inactive)
    else $error("bit changed with no set or reset command");

  property p_set_reset;
    @(posedge clock) disable iff (rst)
      take_edge |=> (regs_ff & $past(set_cmd & ~rst_cmd))
        == $past(set_cmd & ~rst_cmd)
        && (regs_ff & $past(rst_cmd & ~set_cmd)) == 14'h0000;
  endproperty
  a_set_reset: assert property (p_set_reset)
    else $error("set or reset command not obeyed");
endmodule

/* sim/sys_logic_model.sv */
// Purpose: Surrounding logic driving the sequencer clock pin and inputs
// Assumes: Shared by both sequencer instances
// Notes: Pin edges launched on clock rising edges only
`timescale 1ns/1ns
module sys_logic_model (
  input wire logic clock,
  output logic device_clock_pin,
  output logic [10:0] logic_inputs
);
  initial begin
    device_clock_pin = 1'b0;
    logic_inputs = 11'h000;
  end
  // Caller never raises set and reset terms together
  task automatic drive(input logic [10:0] v);
    @(posedge clock);
    logic_inputs <= v;
  endtask
  // Low and high each held a full sample, per pin cycle
  task automatic pulse();
    @(posedge clock);
    device_clock_pin <= 1'b1;
    @(posedge clock);
    device_clock_pin <= 1'b0;
    @(negedge clock);
  endtask
endmodule

/* sim/programmable_sr_state_sequencer_bench.sv */
// Purpose: Self-checking bench for the S/R sequencer
// Assumes: Two terms; ext0 with diag input low clears all, ext1 sets 0,4,6,q1
// Notes: A second, unprogrammed instance uses the enable option
`timescale 1ns/1ns
module programmable_sr_state_sequencer_bench;
  localparam logic [45:0] tl = 46'h000001000001;
  localparam logic [45:0] cl = 46'h000000000800;
  localparam logic [27:0] rl = 28'h5555555;
  localparam logic [27:0] sl = 28'h0802202;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic diag_high = 1'b0;
  logic preset_pin = 1'b0;
  logic enable_n = 1'b0;
  logic diag_in = 1'b0;
  logic pin;
  logic [10:0] ins;
  logic [3:0] st, op, st_b, op_b;
  logic oe, oe_b, ope, ope_b;
  int fail_count = 0;
  int checks = 0;
  always #25 clock = ~clock;
  sys_logic_model model (.clock(clock), .device_clock_pin(pin),
    .logic_inputs(ins));
  sr_sequencer #(.num_terms(2), .and_true_links(tl),
    .and_comp_links(cl), .set_links(sl), .reset_links(rl)) dut (
    .clock(clock), .rst(rst), .device_clock_pin(pin), .logic_inputs(ins),
    .diag_select_input(diag_in), .diag_voltage_high(diag_high),
    .preset_or_enable_pin(preset_pin), .state_output_pins(st),
    .state_output_oe(oe), .output_pins(op), .output_pins_oe(ope));
  // Virgin links, so registers must stay all ones
  sr_sequencer #(.preset_option(1'b0)) dut_oe (
    .clock(clock), .rst(rst), .device_clock_pin(pin),
    .logic_inputs(ins), .diag_select_input(diag_in),
    .diag_voltage_high(diag_high), .preset_or_enable_pin(enable_n),
    .state_output_pins(st_b), .state_output_oe(oe_b),
    .output_pins(op_b), .output_pins_oe(ope_b));
  task automatic check4(input string what, input logic [3:0] e,
    input logic [3:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic check1(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic pins(input logic [3:0] es, input logic [3:0] eo);
    check4("state_output_pins", es, st);
    check4("output_pins", eo, op);
  endtask
  task automatic t_reset();
    pins(4'hf, 4'hf);
    check1("state_output_oe", 1'b1, oe);
    check1("output_pins_oe", 1'b1, ope);
    $display("test reset done");
  endtask
  task automatic t_wait_fall();
    model.drive(11'h001);
    model.pulse();
    pins(4'hf, 4'hf);
    model.pulse();
    pins(4'h0, 4'h0);
    $display("test first edge done");
  endtask
  task automatic t_set_hold();
    model.drive(11'h002);
    model.pulse();
    pins(4'h1, 4'h2);
    model.drive(11'h000);
    model.pulse();
    pins(4'h1, 4'h2);
    $display("test set hold done");
  endtask
  task automatic t_diag();
    @(posedge clock);
    diag_high <= 1'b1;
    @(negedge clock);
    pins(4'h1, 4'h7);
    @(posedge clock);
    diag_high <= 1'b0;
    @(negedge clock);
    pins(4'h1, 4'h2);
    $display("test diag done");
  endtask
  task automatic t_diag_input();
    @(posedge clock);
    diag_in <= 1'b1;
    model.drive(11'h001);
    model.pulse();
    pins(4'h1, 4'h2);
    @(posedge clock);
    diag_in <= 1'b0;
    model.drive(11'h000);
    $display("test diag input done");
  endtask
  task automatic t_enable();
    @(posedge clock);
    enable_n <= 1'b1;
    @(negedge clock);
    check1("state_output_oe", 1'b0, oe_b);
    check1("output_pins_oe", 1'b0, ope_b);
    @(posedge clock);
    enable_n <= 1'b0;
    @(negedge clock);
    check1("state_output_oe", 1'b1, oe_b);
    check1("output_pins_oe", 1'b1, ope_b);
    check4("output_pins", 4'hf, op_b);
    check4("state_output_pins", 4'hf, st_b);
    $display("test enable done");
  endtask
  task automatic t_preset();
    @(posedge clock);
    preset_pin <= 1'b1;
    @(negedge clock);
    pins(4'hf, 4'hf);
    model.drive(11'h001);
    model.pulse();
    pins(4'hf, 4'hf);
    @(posedge clock);
    preset_pin <= 1'b0;
    model.pulse();
    pins(4'hf, 4'hf);
    model.pulse();
    pins(4'h0, 4'h0);
    $display("test preset done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    t_reset();
    t_wait_fall();
    t_set_hold();
    t_diag();
    t_diag_input();
    t_enable();
    t_preset();
    complete_run();
  end
  // Tests need under 100 cycles; generous margin
  initial begin
    repeat (2000) @(posedge clock);
    fail_count++;
    complete_run();
  end
endmodule
